// File: slbg_boot_gate.sv
// slbg_boot_gate: life-cycle tracker and secure boot release gate
// assumes checker, upgrade engine and key fuses sit on the same clock
`timescale 1ns/100ps
module slbg_boot_gate import slbg_pkg::*; #(
    parameter int KEY_W = 128
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // life-cycle control
    input wire logic nvLcsValid,
    input wire slbg_lifecycle_state_type nvLcs,
    input wire logic provisionDone,
    input wire logic eraseSecrets,
    output slbg_lifecycle_state_type lifecycleState,
    output logic secureBootOn,
    output logic debugAvail,
    output logic secretWipe,
    // boot stages
    output logic romExec,
    output logic fwExec,
    output logic chkReq,
    output slbg_stage_type chkStage,
    input wire slbg_result_type chkResult,
    output logic upgReq,
    input wire slbg_result_type upgResult,
    output logic appRstN,
    output logic rtRstN,
    output logic bootFail,
    // root key sources
    input wire logic rootFromPuf,
    input wire logic [KEY_W-1:0] pufKey,
    input wire logic [KEY_W-1:0] rngKey,
    // host services
    input wire logic seUpgradeCmd,
    input wire logic svcValid,
    input wire slbg_svc_req_type svcReq,
    output logic svcAccept,
    output logic svcDeny,
    output logic engKeyValid,
    output logic [KEY_W-1:0] engKey,
    output logic hostKeyValid,
    output logic [KEY_W-1:0] hostKey
);
    typedef enum logic [2:0] {
        BT_SETTLE,
        BT_ROM,
        BT_ROM_UPGRADE,
        BT_ROM_VERIFY,
        BT_FW_VERIFY,
        BT_RUN,
        BT_HALT
    } slbg_boot_state_type;

    slbg_boot_state_type state_reg, state_next;
    slbg_lifecycle_state_type lcs_reg;
    logic [SETTLE_CNT_W-1:0] settle_reg;
    logic upgPending_reg;
    logic [KEY_W-1:0] rootKey_reg;
    logic wipe_reg;
    logic enforce;
    logic chkPass;
    logic svcAllowed;
    logic svcIsStore;
    logic deriveReq;
    logic exportPend_reg;
    logic dkValid;
    logic [KEY_W-1:0] dkKey;

    // enforcement follows the life-cycle; off while uninitialized
    assign enforce = (lcs_reg == LCS_SECURED);
    // an unenforced stage still runs the check but ignores its verdict
    assign chkPass = chkResult.ok || !enforce;

    // life-cycle tracker
    always_ff @(posedge clk) begin
        if (srst) begin
            lcs_reg <= LCS_UNINITIALIZED;
        end else if (eraseSecrets && lcs_reg != LCS_RETURN_FOR_REPAIR) begin
            lcs_reg <= LCS_RETURN_FOR_REPAIR;
        end else if (provisionDone && lcs_reg == LCS_UNINITIALIZED) begin
            lcs_reg <= LCS_SECURED;
        end else if (nvLcsValid && nvLcs > lcs_reg) begin
            lcs_reg <= nvLcs; // fuse copy may only move forward
        end
    end

    // wipe pulse when an erase moves the life-cycle to repair; a fuse copy into repair gives none
    always_ff @(posedge clk) begin
        if (srst) begin
            wipe_reg <= 1'b0;
        end else begin
            wipe_reg <= eraseSecrets && lcs_reg != LCS_RETURN_FOR_REPAIR;
        end
    end

    // supply settle counter ahead of the rom stage
    always_ff @(posedge clk) begin
        if (srst) begin
            settle_reg <= SETTLE_RESET;
        end else if (state_reg == BT_SETTLE && settle_reg != SETTLE_CNT_W'(POR_SETTLE_CYC)) begin
            settle_reg <= settle_reg + 1'b1;
        end
    end

    // boot sequence
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            BT_SETTLE: begin
                if (settle_reg == SETTLE_CNT_W'(POR_SETTLE_CYC)) begin
                    state_next = BT_ROM;
                end
            end
            BT_ROM: begin
                state_next = upgPending_reg ? BT_ROM_UPGRADE : BT_ROM_VERIFY;
            end
            BT_ROM_UPGRADE: begin
                // a failed upgrade keeps the old image, which is then checked
                if (upgResult.done) begin
                    state_next = BT_ROM_VERIFY;
                end
            end
            BT_ROM_VERIFY: begin
                if (chkResult.done) begin
                    state_next = chkPass ? BT_FW_VERIFY : BT_HALT;
                end
            end
            BT_FW_VERIFY: begin
                if (chkResult.done) begin
                    state_next = chkPass ? BT_RUN : BT_HALT;
                end
            end
            BT_RUN: begin
                if (upgPending_reg) begin
                    state_next = BT_ROM; // back to rom with the host held
                end
            end
            BT_HALT: begin
                state_next = BT_HALT; // only a reset leaves here
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= BT_SETTLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // upgrade command from the host; the set wins over the clear
    always_ff @(posedge clk) begin
        if (srst) begin
            upgPending_reg <= 1'b0;
        end else if (seUpgradeCmd && state_reg == BT_RUN) begin
            upgPending_reg <= 1'b1;
        end else if (state_reg == BT_ROM_UPGRADE) begin
            upgPending_reg <= 1'b0;
        end
    end

    // root key: taken at rom entry, zeroed for repair
    always_ff @(posedge clk) begin
        if (srst) begin
            rootKey_reg <= '0;
        end else if (lcs_reg == LCS_RETURN_FOR_REPAIR || eraseSecrets) begin
            rootKey_reg <= '0;
        end else if (state_next == BT_ROM && state_reg != BT_ROM) begin
            rootKey_reg <= rootFromPuf ? pufKey : rngKey;
        end
    end

    // stage strobes, one cycle on entry to each verify or upgrade stage
    always_ff @(posedge clk) begin
        if (srst) begin
            chkReq <= 1'b0;
            upgReq <= 1'b0;
            chkStage <= STAGE_SE_FIRMWARE;
        end else begin
            chkReq <= state_next != state_reg && (state_next == BT_ROM_VERIFY || state_next == BT_FW_VERIFY);
            upgReq <= state_next == BT_ROM_UPGRADE && state_reg != BT_ROM_UPGRADE;
            chkStage <= (state_next == BT_FW_VERIFY) ? STAGE_APP_BOOTLOADER : STAGE_SE_FIRMWARE;
        end
    end

    // processor resets and stage levels
    always_ff @(posedge clk) begin
        if (srst) begin
            appRstN <= 1'b0;
            rtRstN <= 1'b0;
            romExec <= 1'b0;
            fwExec <= 1'b0;
            bootFail <= 1'b0;
        end else begin
            appRstN <= state_next == BT_RUN;
            rtRstN <= state_next == BT_RUN;
            romExec <= state_next == BT_ROM || state_next == BT_ROM_UPGRADE || state_next == BT_ROM_VERIFY;
            fwExec <= state_next == BT_FW_VERIFY || state_next == BT_RUN;
            bootFail <= state_next == BT_HALT;
        end
    end

    // life-cycle outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            lifecycleState <= LCS_UNINITIALIZED;
            secureBootOn <= 1'b0;
            debugAvail <= 1'b0;
            secretWipe <= 1'b0;
        end else begin
            lifecycleState <= lcs_reg;
            secureBootOn <= enforce;
            debugAvail <= enforce;
            secretWipe <= wipe_reg;
        end
    end

    // service policy: repair has no secrets, limits are honoured
    assign svcIsStore = svcReq.kind != SVC_CRYPTO;
    always_comb begin
        svcAllowed = state_reg == BT_RUN;
        if (svcIsStore && lcs_reg == LCS_RETURN_FOR_REPAIR) begin
            svcAllowed = 1'b0;
        end
        if (svcReq.usage[USAGE_LOCKED_BIT]) begin
            svcAllowed = 1'b0;
        end
        if (svcReq.kind == SVC_EXPORT && svcReq.usage[USAGE_INTERNAL_BIT]) begin
            svcAllowed = 1'b0; // internal keys never leave
        end
    end
    assign deriveReq = svcValid && svcAllowed;

    // accept or deny answer, one cycle after the request
    always_ff @(posedge clk) begin
        if (srst) begin
            svcAccept <= 1'b0;
            svcDeny <= 1'b0;
            exportPend_reg <= 1'b0;
        end else begin
            svcAccept <= deriveReq;
            svcDeny <= svcValid && !svcAllowed;
            exportPend_reg <= deriveReq && svcReq.kind == SVC_EXPORT;
        end
    end

    slbg_key_derive #(
        .KEY_W(KEY_W)
    ) uDerive (
        .clk(clk),
        .srst(srst),
        .reqValid(deriveReq),
        .rootKey(rootKey_reg),
        .item(svcReq.item),
        .keyValid(dkValid),
        .itemKey(dkKey)
    );

    // route the item key: engine for internal use, host only on export
    always_ff @(posedge clk) begin
        if (srst) begin
            engKeyValid <= 1'b0;
            engKey <= '0;
            hostKeyValid <= 1'b0;
            hostKey <= '0;
        end else begin
            engKeyValid <= dkValid && !exportPend_reg;
            engKey <= (dkValid && !exportPend_reg) ? dkKey : '0;
            hostKeyValid <= dkValid && exportPend_reg;
            hostKey <= (dkValid && exportPend_reg) ? dkKey : '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_secured_check_fail;
        chkResult.done && !chkResult.ok && enforce
            && (state_reg == BT_ROM_VERIFY || state_reg == BT_FW_VERIFY);
    endsequence

    sequence s_held_in_halt;
        (state_reg == BT_HALT) ##1 (!appRstN && !rtRstN && bootFail) [*3];
    endsequence

    a_reset_starts_uninit: assert property ($fell(srst) |-> lcs_reg == LCS_UNINITIALIZED)
        else $error("life-cycle not uninitialized after reset");
    a_lcs_never_back: assert property (lcs_reg >= $past(lcs_reg))
        else $error("life-cycle moved backwards");
    a_provision_secures: assert property (provisionDone && !eraseSecrets
        && lcs_reg == LCS_UNINITIALIZED |=> lcs_reg == LCS_SECURED ##1 lifecycleState == LCS_SECURED)
        else $error("provisioning did not secure");
    a_erase_to_repair: assert property (eraseSecrets && lcs_reg != LCS_RETURN_FOR_REPAIR
        |=> lcs_reg == LCS_RETURN_FOR_REPAIR && rootKey_reg == '0 ##1 secretWipe)
        else $error("erase did not reach repair state");
    a_boot_only_secured: assert property (##1 (secureBootOn == ($past(lcs_reg) == LCS_SECURED)) && debugAvail == secureBootOn)
        else $error("boot or debug enabled outside secured");
    a_release_after_check: assert property ($rose(appRstN) |-> $past(state_reg) == BT_FW_VERIFY
        && $past(chkResult.done) && ($past(chkResult.ok) || !$past(enforce)))
        else $error("host released without a passing check");
    a_fail_holds_reset: assert property (s_secured_check_fail |=> s_held_in_halt)
        else $error("failed check did not hold processors");
    a_rom_before_fw: assert property ($rose(fwExec) |-> $past(romExec))
        else $error("firmware ran before the rom stage");
    a_settle_holds: assert property ($fell(srst) |-> (!appRstN && !rtRstN) [*8])
        else $error("processors left reset during power-up");
    a_upgrade_strobe: assert property (state_reg == BT_ROM && upgPending_reg |=> upgReq ##1 romExec)
        else $error("pending upgrade not started by rom");
    a_export_blocked: assert property (svcValid && svcReq.kind == SVC_EXPORT && svcReq.usage[USAGE_INTERNAL_BIT]
        |=> svcDeny ##1 !hostKeyValid && hostKey == '0)
        else $error("internal-only key was exported");
    a_service_answers: assert property (svcValid |=> svcAccept != svcDeny)
        else $error("service request left unanswered");
endmodule

// File: slbg_pkg.sv
// slbg_pkg: types and constants of the life-cycle tracker and boot release gate
// assumes one 100 MHz clock and a synchronous power-on reset; no software registers
package slbg_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // supply settle time before the rom stage starts
    localparam int POR_SETTLE_NS = 100;
    localparam int POR_SETTLE_CYC = (POR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CNT_W = $clog2(POR_SETTLE_CYC + 1);
    localparam int ITEM_W = 8;
    localparam int USAGE_INTERNAL_BIT = 0;
    localparam int USAGE_LOCKED_BIT = 1;
    localparam logic [SETTLE_CNT_W-1:0] SETTLE_RESET = '0;

    typedef enum logic [1:0] {
        LCS_UNINITIALIZED,
        LCS_SECURED,
        LCS_RETURN_FOR_REPAIR
    } slbg_lifecycle_state_type;

    typedef enum logic {
        STAGE_SE_FIRMWARE,
        STAGE_APP_BOOTLOADER
    } slbg_stage_type;

    typedef enum logic [1:0] {
        SVC_CRYPTO,
        SVC_WRAP,
        SVC_UNWRAP,
        SVC_EXPORT
    } slbg_svc_kind_type;

    // answer of the signature checker or the upgrade engine
    typedef struct packed {
        logic done;
        logic ok;
    } slbg_result_type;

    // one security service request from the host
    typedef struct packed {
        slbg_svc_kind_type kind;
        logic [ITEM_W-1:0] item;
        logic [1:0] usage;
    } slbg_svc_req_type;
endpackage

// File: slbg_key_derive.sv
// slbg_key_derive: per-item key from the storage root key
// assumes the real key derivation lives in the crypto datapath; this is its stand-in mix
`timescale 1ns/100ps
module slbg_key_derive import slbg_pkg::*; #(
    parameter int KEY_W = 128
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // request
    input wire logic reqValid,
    input wire logic [KEY_W-1:0] rootKey,
    input wire logic [ITEM_W-1:0] item,
    // derived key, one cycle after the request
    output logic keyValid,
    output logic [KEY_W-1:0] itemKey
);
    logic [KEY_W-1:0] mixNext;

    // every byte depends on item and lane, so no two items share a key
    for (genvar g = 0; g < KEY_W / 8; g++) begin : gMix
        assign mixNext[g*8 +: 8] = rootKey[g*8 +: 8] ^ (item + 8'(g));
    end

    // valid strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            keyValid <= 1'b0;
        end else begin
            keyValid <= reqValid;
        end
    end

    // key register; cleared when idle so no stale key lingers
    always_ff @(posedge clk) begin
        if (srst) begin
            itemKey <= '0;
        end else if (reqValid) begin
            itemKey <= mixNext;
        end else begin
            itemKey <= '0;
        end
    end

    a_key_follows_req: assert property (@(posedge clk) disable iff (srst)
        reqValid |=> keyValid && itemKey == $past(mixNext))
        else $error("derived key missing after request");
endmodule

// File: slbg_chk_model.sv
// slbg_chk_model: far-side stand-in for the signature checker and upgrade engine
// assumes the gate's clock; verdicts and answer latency are set by the bench
`timescale 1ns/100ps
module slbg_chk_model import slbg_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // requests from the gate
    input wire logic chkReq,
    input wire slbg_stage_type chkStage,
    input wire logic upgReq,
    // verdicts and latency chosen by the bench
    input wire logic fwOk,
    input wire logic appOk,
    input wire logic [3:0] lat,
    // answers
    output slbg_result_type chkResult,
    output slbg_result_type upgResult
);
    logic chkBusy_reg;
    logic upgBusy_reg;
    logic okHold_reg;
    logic noise_reg;
    logic [3:0] chkCnt_reg;
    logic [3:0] upgCnt_reg;
    logic chkDone;
    logic upgDone;

    // ok toggles outside done so a stale verdict never looks like a fresh one
    always_ff @(posedge clk) begin
        noise_reg <= srst ? 1'b0 : ~noise_reg;
    end

    // signature check: one verdict per request, lat+1 cycles after it
    always_ff @(posedge clk) begin
        if (srst) begin
            chkBusy_reg <= 1'b0;
            chkCnt_reg <= 4'h0;
            okHold_reg <= 1'b0;
        end else if (chkReq) begin
            chkBusy_reg <= 1'b1;
            chkCnt_reg <= lat;
            okHold_reg <= (chkStage == STAGE_APP_BOOTLOADER) ? appOk : fwOk;
        end else if (chkBusy_reg) begin
            chkBusy_reg <= (chkCnt_reg != 4'h0);
            chkCnt_reg <= chkCnt_reg - 4'h1;
        end
    end

    // upgrade engine: finishes lat+1 cycles after its request
    always_ff @(posedge clk) begin
        if (srst) begin
            upgBusy_reg <= 1'b0;
            upgCnt_reg <= 4'h0;
        end else if (upgReq) begin
            upgBusy_reg <= 1'b1;
            upgCnt_reg <= lat;
        end else if (upgBusy_reg) begin
            upgBusy_reg <= (upgCnt_reg != 4'h0);
            upgCnt_reg <= upgCnt_reg - 4'h1;
        end
    end

    // done is a one-cycle pulse; ok only means something with it
    assign chkDone = chkBusy_reg && (chkCnt_reg == 4'h0);
    assign upgDone = upgBusy_reg && (upgCnt_reg == 4'h0);
    assign chkResult = '{done: chkDone, ok: chkDone ? okHold_reg : noise_reg};
    assign upgResult = '{done: upgDone, ok: upgDone ? 1'b1 : noise_reg};
endmodule

// File: testbench.sv
// testbench: scenario tasks for the life-cycle tracker and boot gate
// assumes slbg_chk_model answers checks; inputs change on the falling edge
`timescale 1ns/100ps
module testbench import slbg_pkg::*; ;
    logic clk, srst, nvLcsValid, provisionDone, eraseSecrets, rootFromPuf, seUpgradeCmd, svcValid;
    slbg_lifecycle_state_type nvLcs, lifecycleState;
    logic secureBootOn, debugAvail, secretWipe, romExec, fwExec, chkReq, upgReq, appRstN, rtRstN, bootFail;
    slbg_stage_type chkStage;
    slbg_result_type chkResult, upgResult;
    logic [127:0] pufKey, rngKey, engKey, hostKey;
    slbg_svc_req_type svcReq;
    logic svcAccept, svcDeny, engKeyValid, hostKeyValid, fwOk, appOk;
    logic [3:0] lat;
    int errors = 0;
    int check_count = 0;

    slbg_boot_gate #(.KEY_W(128)) u_slbg_boot_gate (.clk(clk), .srst(srst), .nvLcsValid(nvLcsValid),
        .nvLcs(nvLcs), .provisionDone(provisionDone), .eraseSecrets(eraseSecrets),
        .lifecycleState(lifecycleState), .secureBootOn(secureBootOn), .debugAvail(debugAvail),
        .secretWipe(secretWipe), .romExec(romExec), .fwExec(fwExec), .chkReq(chkReq), .chkStage(chkStage),
        .chkResult(chkResult), .upgReq(upgReq), .upgResult(upgResult), .appRstN(appRstN), .rtRstN(rtRstN),
        .bootFail(bootFail), .rootFromPuf(rootFromPuf), .pufKey(pufKey), .rngKey(rngKey),
        .seUpgradeCmd(seUpgradeCmd), .svcValid(svcValid), .svcReq(svcReq), .svcAccept(svcAccept),
        .svcDeny(svcDeny), .engKeyValid(engKeyValid), .engKey(engKey), .hostKeyValid(hostKeyValid),
        .hostKey(hostKey));
    slbg_chk_model u_slbg_chk_model (.clk(clk), .srst(srst), .chkReq(chkReq), .chkStage(chkStage),
        .upgReq(upgReq), .fwOk(fwOk), .appOk(appOk), .lat(lat), .chkResult(chkResult), .upgResult(upgResult));

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // comparisons, one per kind of result
    task automatic check_bit(input logic got, input logic exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s: got %b want %b", $time, msg, got, exp);
        end
    endtask
    task automatic check_vec(input logic [127:0] got, input logic [127:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s: got %h want %h", $time, msg, got, exp);
        end
    endtask

    // expected per-item key: root byte g mixed with item plus g
    function automatic logic [127:0] item_key(input logic [127:0] root, input logic [7:0] item);
        logic [127:0] k;
        for (int g = 0; g < 16; g++) k[g*8+:8] = root[g*8+:8] ^ (item + 8'(g));
        return k;
    endfunction

    // bounded wait for the processors to leave reset
    task automatic wait_run(input string msg);
        int n;
        n = 0;
        while (appRstN !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check_bit(appRstN, 1'b1, msg);
    endtask

    task automatic do_reset();
        @(negedge clk);
        srst = 1'b1;
        repeat (20) @(negedge clk);
        srst = 1'b0;
    endtask

    // one service request; answer one cycle on, key one more cycle on
    task automatic svc(input slbg_svc_kind_type k, input logic [7:0] it, input logic [1:0] u,
                       input logic acc, input logic toHost, input logic [127:0] key);
        svcReq = '{kind: k, item: it, usage: u};
        svcValid = 1'b1;
        @(negedge clk);
        svcValid = 1'b0;
        check_bit(svcAccept, acc, "accept");
        check_bit(svcDeny, ~acc, "deny");
        @(negedge clk);
        check_bit(engKeyValid, acc & ~toHost, "engine key valid");
        check_bit(hostKeyValid, acc & toHost, "host key valid");
        check_vec(engKey, (acc & ~toHost) ? key : '0, "engine key");
        check_vec(hostKey, (acc & toHost) ? key : '0, "host key");
    endtask

    // power-up: held in reset, rom first, then release after both checks pass
    task automatic t_boot();
        do_reset();
        check_bit(appRstN, 1'b0, "app reset at power-up");
        check_bit(rtRstN, 1'b0, "rt reset at power-up");
        check_vec(128'(lifecycleState), 128'(LCS_UNINITIALIZED), "fresh state");
        check_bit(secureBootOn | debugAvail, 1'b0, "features off when fresh");
        repeat (12) @(negedge clk);
        check_bit(romExec & ~fwExec, 1'b1, "rom stage first");
        check_bit(appRstN, 1'b0, "held during rom");
        wait_run("app released after checks");
        check_bit(rtRstN & fwExec & ~romExec, 1'b1, "firmware running, rt released");
    endtask

    // services in the running state
    task automatic t_services(input logic [127:0] root, input logic [7:0] it);
        svc(SVC_WRAP, it, 2'b00, 1'b1, 1'b0, item_key(root, it));
        svc(SVC_CRYPTO, it, 2'b00, 1'b1, 1'b0, item_key(root, it));
        svc(SVC_EXPORT, it, 2'b00, 1'b1, 1'b1, item_key(root, it));
        svc(SVC_EXPORT, it, 2'b01, 1'b0, 1'b1, '0);
        svc(SVC_UNWRAP, it, 2'b10, 1'b0, 1'b0, '0);
    endtask

    // provisioning, then an attempted backward fuse load
    task automatic t_provision();
        provisionDone = 1'b1;
        @(negedge clk);
        provisionDone = 1'b0;
        @(negedge clk);
        check_vec(128'(lifecycleState), 128'(LCS_SECURED), "secured after provisioning");
        check_bit(secureBootOn & debugAvail, 1'b1, "enforcement on when secured");
        nvLcs = LCS_UNINITIALIZED;
        nvLcsValid = 1'b1;
        @(negedge clk);
        nvLcsValid = 1'b0;
        repeat (3) @(negedge clk);
        check_vec(128'(lifecycleState), 128'(LCS_SECURED), "no backward load");
    endtask

    // host-triggered firmware upgrade through the rom stage, root from rng afterwards
    task automatic t_upgrade();
        int n;
        rootFromPuf = 1'b0;
        seUpgradeCmd = 1'b1;
        @(negedge clk);
        seUpgradeCmd = 1'b0;
        n = 0;
        while (upgReq !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check_bit(upgReq, 1'b1, "upgrade started");
        check_bit(romExec & ~appRstN & ~rtRstN, 1'b1, "rom upgrade holds processors");
        wait_run("back to run after upgrade");
        t_services(rngKey, 8'h09);
    endtask

    // erase secrets, then try to go back
    task automatic t_erase();
        eraseSecrets = 1'b1;
        @(negedge clk);
        eraseSecrets = 1'b0;
        @(negedge clk);
        check_bit(secretWipe, 1'b1, "wipe pulse");
        check_vec(128'(lifecycleState), 128'(LCS_RETURN_FOR_REPAIR), "repair state");
        check_bit(secureBootOn | debugAvail, 1'b0, "enforcement off in repair");
        @(negedge clk);
        check_bit(secretWipe, 1'b0, "wipe is one cycle");
        provisionDone = 1'b1;
        @(negedge clk);
        provisionDone = 1'b0;
        repeat (2) @(negedge clk);
        check_vec(128'(lifecycleState), 128'(LCS_RETURN_FOR_REPAIR), "no return from repair");
        svc(SVC_WRAP, 8'h05, 2'b00, 1'b0, 1'b0, '0);
        // root is zeroed in repair, so the derived key carries no secret
        svc(SVC_CRYPTO, 8'h05, 2'b00, 1'b1, 1'b0, item_key('0, 8'h05));
    endtask

    // secured part with a bad signature stops and keeps both processors in reset
    task automatic t_fail(input logic fw, input logic app);
        logic seenFw;
        fwOk = fw;
        appOk = app;
        do_reset();
        seenFw = 1'b0;
        nvLcs = LCS_SECURED;
        nvLcsValid = 1'b1;
        @(negedge clk);
        nvLcsValid = 1'b0;
        // firmware stage drops again on halt, so remember whether it ever ran
        repeat (120) begin
            @(negedge clk);
            seenFw = seenFw | fwExec;
        end
        check_bit(bootFail, 1'b1, "halt on bad signature");
        check_bit(seenFw, fw, "firmware only after its check");
        check_bit(appRstN | rtRstN, 1'b0, "processors stay in reset");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        #50000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end

    initial begin
        srst = 1'b1;
        nvLcsValid = 1'b0;
        nvLcs = LCS_UNINITIALIZED;
        provisionDone = 1'b0;
        eraseSecrets = 1'b0;
        rootFromPuf = 1'b1;
        pufKey = {16{8'ha5}};
        rngKey = {4{32'h1234_5678}};
        seUpgradeCmd = 1'b0;
        svcValid = 1'b0;
        svcReq = '0;
        fwOk = 1'b1;
        appOk = 1'b1;
        lat = 4'h0;
        t_boot();
        t_services(pufKey, 8'h05);
        lat = 4'h7;
        t_provision();
        t_upgrade();
        t_erase();
        t_fail(1'b0, 1'b1);
        t_fail(1'b1, 1'b0);
        results();
    end
endmodule
